// File: common/lbf_pkg.sv
// Purpose: Shared constants and types for the local bus front end.
// Assumes: One 100 MHz clock shared by both ends.
// Notes: Active-low link signals carry an _n suffix.
package lbf_pkg;
    localparam int ADDR_HI = 31;
    localparam int ADDR_LO = 3;
    localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
    localparam int INQ_LO = 5;
    localparam int A20_POS = 20;
    localparam int BE_W = 8;
    localparam int PCHK_LAT = 2;
    localparam logic [BE_W-1:0] BE_IDLE = 8'hff;
    localparam logic [ADDR_W-1:0] ADDR_RST = 29'h0;

    typedef enum logic [1:0] {
        LBF_IDLE,
        LBF_ADDR,
        LBF_DATA,
        LBF_HOLD
    } lbf_state_t;

    // Even parity over the inquiry field (address bits 31 to 5).
    function automatic logic lbf_parity(input logic [ADDR_HI:ADDR_LO] a);
        lbf_parity = ^a[ADDR_HI:INQ_LO];
    endfunction : lbf_parity
endpackage : lbf_pkg

// File: common/lbf_if.sv
// Purpose: Link between the processor front end and the system controller.
// Assumes: Both ends run on clk; tri-state lines are split into in/out/oe.
// Notes: Resolved levels are computed here from the output enables.
`timescale 1ns/1ps
interface lbf_if import lbf_pkg::*; (
    input wire logic clk
);
    logic [ADDR_W-1:0] cpu_addr_out;
    logic cpu_addr_oe;
    logic [ADDR_W-1:0] sys_addr_out;
    logic sys_addr_oe;
    logic cpu_ap_out;
    logic cpu_ap_oe;
    logic sys_ap_out;
    logic sys_ap_oe;
    logic [BE_W-1:0] cpu_be_n_out;
    logic cpu_be_oe;
    logic [BE_W-1:0] sys_be_n_out;
    logic sys_be_oe;
    logic cycle_start_strobe_n;
    logic cache_cycle_start_strobe_n;
    logic write_read;
    logic address_parity_error_out_n;
    logic addr_bit_twenty_mask_in_n;
    logic address_float_request;
    logic byte_select_float_request;
    logic backoff_request_n;
    logic inquiry_address_strobe_n;
    logic cycle_done;
    logic [ADDR_W-1:0] address_lines;
    logic address_parity_bit;
    logic [BE_W-1:0] byte_lane_selects_n;

    // Undriven lines read as pulled up; a clash resolves in favour of the system.
    assign address_lines = sys_addr_oe ? sys_addr_out : (cpu_addr_oe ? cpu_addr_out : '1);
    assign address_parity_bit = sys_ap_oe ? sys_ap_out : (cpu_ap_oe ? cpu_ap_out : 1'b1);
    assign byte_lane_selects_n = sys_be_oe ? sys_be_n_out : (cpu_be_oe ? cpu_be_n_out : BE_IDLE);

    modport cpu (
        input clk, address_lines, address_parity_bit, byte_lane_selects_n,
        input addr_bit_twenty_mask_in_n, address_float_request, byte_select_float_request,
        input backoff_request_n, inquiry_address_strobe_n, cycle_done,
        output cpu_addr_out, cpu_addr_oe, cpu_ap_out, cpu_ap_oe, cpu_be_n_out, cpu_be_oe,
        output cycle_start_strobe_n, cache_cycle_start_strobe_n, write_read, address_parity_error_out_n
    );
    modport sys (
        input clk, address_lines, address_parity_bit, byte_lane_selects_n,
        input cycle_start_strobe_n, cache_cycle_start_strobe_n, write_read, address_parity_error_out_n,
        input cpu_addr_oe, cpu_be_oe,
        output sys_addr_out, sys_addr_oe, sys_ap_out, sys_ap_oe, sys_be_n_out, sys_be_oe,
        output addr_bit_twenty_mask_in_n, address_float_request, byte_select_float_request,
        output backoff_request_n, inquiry_address_strobe_n, cycle_done
    );
endinterface : lbf_if

// File: logic/lbf_parity_check.sv
// Purpose: Inquiry address parity checker with a two clock result.
// Assumes: Address and parity are valid in the strobe cycle.
// Notes: Error output is low for one clock, two clocks after the strobe.
`timescale 1ns/1ps
module lbf_parity_check import lbf_pkg::*; (
    input wire logic clk, // Bus clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic strobe, // Inquiry strobe sampled active.
    input wire logic [ADDR_HI:ADDR_LO] addr, // Received address.
    input wire logic par, // Received parity bit.
    output logic err_n // Parity error, active low.
);
    logic stage1_reg;
    logic err_n_reg;

    // Even parity means the XOR of field and bit is zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= 1'b0;
        end else begin
            stage1_reg <= strobe && (lbf_parity(addr) != par);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_n_reg <= 1'b1;
        end else begin
            err_n_reg <= ~stage1_reg;
        end
    end

    assign err_n = err_n_reg;
endmodule : lbf_parity_check

// File: logic/lbf_cpu_end.sv
// Purpose: Processor end of the local bus: address, parity, byte lanes, strobes, holds.
// Assumes: Core requests a cycle with req_valid and holds it until req_ready.
// Notes: No data path; the system ends the cycle with cycle_done.
`timescale 1ns/1ps
module lbf_cpu_end import lbf_pkg::*; #(
    parameter int ADDR_WIDTH = ADDR_W
) (
    input wire logic clk, // Bus clock, 100 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    lbf_if.cpu bus, // Link to the system side.
    input wire logic req_valid, // Core requests a bus cycle.
    output logic req_ready, // Request accepted this clock.
    input wire logic [ADDR_HI:ADDR_LO] req_addr, // Cycle address.
    input wire logic [BE_W-1:0] req_be, // Active bytes, active high.
    input wire logic req_write, // One for write, zero for read.
    input wire logic sg_enable, // Scatter/gather interface enabled.
    output logic cyc_aborted, // One-clock pulse: cycle backed off.
    output logic cyc_finished, // One-clock pulse: cycle completed.
    output logic inq_valid, // One-clock pulse: inquiry address taken.
    output logic [ADDR_HI:INQ_LO] inq_line // Line selected by the inquiry.
);
    lbf_state_t state_reg;
    lbf_state_t state_next;
    logic [ADDR_HI:ADDR_LO] addr_reg;
    logic [BE_W-1:0] be_n_reg;
    logic write_reg;
    logic addr_float_reg;
    logic be_float_reg;
    logic ads_n_reg;
    logic aborted_reg;
    logic finished_reg;
    logic inq_valid_reg;
    logic [ADDR_HI:INQ_LO] inq_line_reg;
    logic [ADDR_HI:ADDR_LO] masked_addr;
    logic backoff;
    logic mask_a20;
    logic inq_strobe;

    // The link fixes the address width, so any other value cannot be carried across it.
    if (ADDR_WIDTH != ADDR_W) begin : g_width_check
        $error("lbf_cpu_end: ADDR_WIDTH must equal the link address width.");
    end

    // One decode serves every released line, so hold and float can never disagree.
    function automatic logic may_drive(input lbf_state_t st, input logic floated);
        may_drive = (st != LBF_HOLD) && !floated;
    endfunction : may_drive

    function automatic logic in_cycle(input lbf_state_t st);
        in_cycle = (st == LBF_ADDR) || (st == LBF_DATA);
    endfunction : in_cycle

    // Back-off, A20 mask and inquiry strobe are active low on the wire; they are decoded once here.
    assign backoff = ~bus.backoff_request_n;
    assign mask_a20 = ~bus.addr_bit_twenty_mask_in_n;
    assign inq_strobe = ~bus.inquiry_address_strobe_n;

    always_comb begin
        masked_addr = req_addr;
        if (mask_a20) begin
            masked_addr[A20_POS] = 1'b0;
        end
    end

    // A new cycle only starts from idle with the bus not backed off.
    assign req_ready = (state_reg == LBF_IDLE) && req_valid && !backoff;

    // Back-off wins over a cycle_done in the same clock, so an aborted cycle is never also finished.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LBF_IDLE: begin
                if (backoff) begin
                    state_next = LBF_HOLD;
                end else if (req_valid) begin
                    state_next = LBF_ADDR;
                end
            end
            LBF_ADDR, LBF_DATA: begin
                if (backoff) begin
                    state_next = LBF_HOLD;
                end else if (bus.cycle_done && state_reg == LBF_DATA) begin
                    state_next = LBF_IDLE;
                end else begin
                    state_next = LBF_DATA;
                end
            end
            LBF_HOLD: begin
                if (!backoff) begin
                    state_next = LBF_IDLE;
                end
            end
            default: begin
                state_next = LBF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= LBF_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Cycle attributes are captured once so they stay stable for the whole cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_reg <= ADDR_RST;
            be_n_reg <= BE_IDLE;
            write_reg <= 1'b0;
        end else if (req_ready) begin
            addr_reg <= masked_addr;
            be_n_reg <= ~req_be;
            write_reg <= req_write;
        end
    end

    // The strobe is registered, so it is low for exactly the clock after the request is taken.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ads_n_reg <= 1'b1;
        end else begin
            ads_n_reg <= ~req_ready;
        end
    end

    // Float flags follow the requests with one clock delay; the byte select flag also needs sg_enable set.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_float_reg <= 1'b0;
            be_float_reg <= 1'b0;
        end else begin
            addr_float_reg <= bus.address_float_request;
            be_float_reg <= bus.byte_select_float_request && sg_enable;
        end
    end

    // Abort and finish pulses exclude each other: back-off masks the finish.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aborted_reg <= 1'b0;
            finished_reg <= 1'b0;
        end else begin
            aborted_reg <= in_cycle(state_reg) && backoff;
            finished_reg <= state_reg == LBF_DATA && !backoff && bus.cycle_done;
        end
    end

    // Inquiry address is taken raw from the bus; the A20 mask is not applied.
    // An inquiry may come in address hold or bus hold, so nothing here looks at the state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inq_valid_reg <= 1'b0;
            inq_line_reg <= '0;
        end else begin
            inq_valid_reg <= inq_strobe;
            if (inq_strobe) begin
                inq_line_reg <= bus.address_lines[ADDR_W-1:INQ_LO-ADDR_LO];
            end
        end
    end

    lbf_parity_check lbf_parity_check_inst (
        .clk(clk),
        .rst(rst),
        .strobe(inq_strobe),
        .addr(bus.address_lines),
        .par(bus.address_parity_bit),
        .err_n(bus.address_parity_error_out_n)
    );

    // Parity comes from the registered address, so it only changes when a new cycle is taken.
    assign bus.cpu_addr_out = addr_reg;
    assign bus.cpu_ap_out = lbf_parity(addr_reg);
    assign bus.cpu_addr_oe = may_drive(state_reg, addr_float_reg);
    assign bus.cpu_ap_oe = may_drive(state_reg, addr_float_reg);
    assign bus.cpu_be_n_out = be_n_reg;
    assign bus.cpu_be_oe = may_drive(state_reg, be_float_reg);
    assign bus.cycle_start_strobe_n = ads_n_reg;
    assign bus.cache_cycle_start_strobe_n = ads_n_reg;
    assign bus.write_read = write_reg;
    assign cyc_aborted = aborted_reg;
    assign cyc_finished = finished_reg;
    assign inq_valid = inq_valid_reg;
    assign inq_line = inq_line_reg;
endmodule : lbf_cpu_end

// File: logic/lbf_sys_end.sv
// Purpose: System controller end: drives holds, back-off, inquiries, cycle ends.
// Assumes: User controls arrive as levels or one-clock pulses on clk.
// Notes: Inquiry drives address and parity for exactly the strobe clock.
`timescale 1ns/1ps
module lbf_sys_end import lbf_pkg::*; (
    input wire logic clk, // Bus clock, 100 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    lbf_if.sys bus, // Link to the processor side.
    input wire logic mask_a20, // Level: mask address bit twenty.
    input wire logic float_addr, // Level: address float request.
    input wire logic float_be, // Level: byte select float request.
    input wire logic [BE_W-1:0] ext_be, // Bytes chosen while selects floated, active high.
    input wire logic backoff, // Level: back-off request.
    input wire logic end_cycle, // Level: end current cycle when possible.
    input wire logic inq_req, // Pulse: run an inquiry.
    input wire logic [ADDR_HI:ADDR_LO] inq_addr, // Inquiry address.
    input wire logic inq_bad_par, // Force wrong parity on this inquiry.
    output logic cycle_seen, // Pulse: start strobe observed.
    output logic [ADDR_HI:ADDR_LO] seen_addr, // Address of last started cycle.
    output logic [BE_W-1:0] seen_be_n, // Byte selects of last started cycle.
    output logic seen_write, // Direction of last started cycle.
    output logic par_err // Pulse: parity error reported.
);
    logic inq_reg;
    logic [ADDR_HI:ADDR_LO] inq_addr_reg;
    logic inq_par_reg;
    logic seen_reg;
    logic [ADDR_HI:ADDR_LO] seen_addr_reg;
    logic [BE_W-1:0] seen_be_n_reg;
    logic seen_write_reg;
    logic par_err_reg;

    // Inquiry only proceeds while the processor has released the address lines.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inq_reg <= 1'b0;
            inq_addr_reg <= ADDR_RST;
            inq_par_reg <= 1'b0;
        end else begin
            inq_reg <= inq_req && !bus.cpu_addr_oe;
            inq_addr_reg <= inq_addr;
            inq_par_reg <= lbf_parity(inq_addr) ^ inq_bad_par;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_reg <= 1'b0;
            seen_addr_reg <= ADDR_RST;
            seen_be_n_reg <= BE_IDLE;
            seen_write_reg <= 1'b0;
            par_err_reg <= 1'b0;
        end else begin
            seen_reg <= ~bus.cycle_start_strobe_n;
            par_err_reg <= ~bus.address_parity_error_out_n;
            if (!bus.cycle_start_strobe_n) begin
                seen_addr_reg <= bus.address_lines;
                seen_be_n_reg <= bus.byte_lane_selects_n;
                seen_write_reg <= bus.write_read;
            end
        end
    end

    assign bus.addr_bit_twenty_mask_in_n = ~mask_a20;
    assign bus.address_float_request = float_addr;
    assign bus.byte_select_float_request = float_be;
    assign bus.backoff_request_n = ~backoff;
    assign bus.cycle_done = end_cycle;
    assign bus.inquiry_address_strobe_n = ~inq_reg;
    assign bus.sys_addr_out = inq_addr_reg;
    assign bus.sys_addr_oe = inq_reg;
    assign bus.sys_ap_out = inq_par_reg;
    assign bus.sys_ap_oe = inq_reg;
    assign bus.sys_be_n_out = ~ext_be;
    assign bus.sys_be_oe = float_be && !bus.cpu_be_oe;
    assign cycle_seen = seen_reg;
    assign seen_addr = seen_addr_reg;
    assign seen_be_n = seen_be_n_reg;
    assign seen_write = seen_write_reg;
    assign par_err = par_err_reg;
endmodule : lbf_sys_end

// File: tb/lbf_monitor.sv
// Purpose: Concurrent checks on the link between the two ends of the local bus.
// Assumes: One clock domain; reset is active high.
// Notes: Sees only interface signals, so scatter/gather gating is judged by the bench.
`timescale 1ns/1ps
module lbf_monitor import lbf_pkg::*; (
    input wire logic clk, // Bus clock.
    input wire logic rst, // Reset, active high.
    input wire logic [ADDR_W-1:0] cpu_addr_out, // Processor address drive.
    input wire logic cpu_addr_oe, // Processor address enable.
    input wire logic cpu_ap_out, // Processor parity drive.
    input wire logic cpu_ap_oe, // Processor parity enable.
    input wire logic cpu_be_oe, // Processor byte select enable.
    input wire logic cycle_start_strobe_n, // Start strobe.
    input wire logic cache_cycle_start_strobe_n, // Cache start strobe.
    input wire logic address_parity_error_out_n, // Parity error.
    input wire logic address_float_request, // Address float request.
    input wire logic backoff_request_n, // Back-off request.
    input wire logic inquiry_address_strobe_n, // Inquiry strobe.
    input wire logic [ADDR_W-1:0] address_lines, // Resolved address.
    input wire logic address_parity_bit // Resolved parity.
);
    logic inq_bad;
    logic inq_good;
    assign inq_bad = !inquiry_address_strobe_n && (address_parity_bit != ^address_lines[ADDR_W-1:INQ_LO-ADDR_LO]);
    assign inq_good = !inquiry_address_strobe_n && !inq_bad;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // A second bad inquiry right behind the first may legally stretch the pulse.
    sequence err_window;
        !address_parity_error_out_n ##1 (address_parity_error_out_n || $past(inq_bad, 2));
    endsequence

    a_strobe_mirror: assert property (cycle_start_strobe_n == cache_cycle_start_strobe_n)
        else $error("cache start strobe differs from start strobe");
    a_strobe_single: assert property (!cycle_start_strobe_n |=> cycle_start_strobe_n)
        else $error("start strobe longer than one clock");
    a_parity_even_out: assert property (!cycle_start_strobe_n && cpu_ap_oe |-> cpu_ap_out == ^cpu_addr_out[ADDR_W-1:2])
        else $error("address parity output not even");
    a_addr_float_release: assert property (address_float_request |=> !cpu_addr_oe && !cpu_ap_oe)
        else $error("address not released after float request");
    a_backoff_release: assert property (!backoff_request_n |=> !(cpu_addr_oe || cpu_ap_oe || cpu_be_oe))
        else $error("bus not released after back-off");
    a_backoff_no_start: assert property (!backoff_request_n |=> cycle_start_strobe_n)
        else $error("cycle started during back-off");
    a_check_bad_par: assert property (inq_bad |-> ##2 err_window)
        else $error("parity error pulse wrong");
    a_check_good_par: assert property (inq_good && !$past(inq_bad) |-> ##2 address_parity_error_out_n)
        else $error("parity error on good inquiry");
endmodule : lbf_monitor

// File: tb/test_cpu_local_bus_front_end.sv
// Purpose: Self-checking bench joining both ends of the local bus front end.
// Assumes: Inputs change at the falling edge; outputs are read there too.
// Notes: Expected values come from the stimulus values alone.
`timescale 1ns/1ps
module test_cpu_local_bus_front_end import lbf_pkg::*;;
    logic clk, rst, req_valid, req_ready, req_write, sg_enable, mask_a20, float_addr, float_be;
    logic backoff, end_cycle, inq_req, inq_bad_par, cyc_aborted, cyc_finished, inq_valid;
    logic cycle_seen, seen_write, par_err;
    logic [ADDR_HI:ADDR_LO] req_addr, inq_addr, seen_addr;
    logic [BE_W-1:0] req_be, ext_be, seen_be_n;
    logic [ADDR_HI:INQ_LO] inq_line;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    lbf_if bus_if (.clk(clk));
    lbf_cpu_end lbf_cpu_end_inst (.clk(clk), .rst(rst), .bus(bus_if), .req_valid(req_valid),
        .req_ready(req_ready), .req_addr(req_addr), .req_be(req_be), .req_write(req_write),
        .sg_enable(sg_enable), .cyc_aborted(cyc_aborted), .cyc_finished(cyc_finished),
        .inq_valid(inq_valid), .inq_line(inq_line));
    lbf_sys_end lbf_sys_end_inst (.clk(clk), .rst(rst), .bus(bus_if), .mask_a20(mask_a20),
        .float_addr(float_addr), .float_be(float_be), .ext_be(ext_be), .backoff(backoff),
        .end_cycle(end_cycle), .inq_req(inq_req), .inq_addr(inq_addr), .inq_bad_par(inq_bad_par),
        .cycle_seen(cycle_seen), .seen_addr(seen_addr), .seen_be_n(seen_be_n),
        .seen_write(seen_write), .par_err(par_err));
    lbf_monitor lbf_monitor_inst (.clk(clk), .rst(rst), .cpu_addr_out(bus_if.cpu_addr_out),
        .cpu_addr_oe(bus_if.cpu_addr_oe), .cpu_ap_out(bus_if.cpu_ap_out), .cpu_ap_oe(bus_if.cpu_ap_oe),
        .cpu_be_oe(bus_if.cpu_be_oe), .cycle_start_strobe_n(bus_if.cycle_start_strobe_n),
        .cache_cycle_start_strobe_n(bus_if.cache_cycle_start_strobe_n),
        .address_parity_error_out_n(bus_if.address_parity_error_out_n),
        .address_float_request(bus_if.address_float_request), .backoff_request_n(bus_if.backoff_request_n),
        .inquiry_address_strobe_n(bus_if.inquiry_address_strobe_n), .address_lines(bus_if.address_lines),
        .address_parity_bit(bus_if.address_parity_bit));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Polls at falling edges so registered outputs have settled.
    task automatic wait_cycle_seen;
        for (int n = 0; n < 20 && cycle_seen !== 1'b1; n++) @(negedge clk);
    endtask : wait_cycle_seen

    task automatic start_cycle(input logic [31:0] a, input logic [7:0] be, input logic wr);
        @(negedge clk);
        req_addr = a[31:3];
        req_be = be;
        req_write = wr;
        req_valid = 1'b1;
        // Let the combinational ready settle, so the request is dropped right after the taking edge.
        #1;
        for (int n = 0; n < 20 && req_ready !== 1'b1; n++) begin
            @(negedge clk);
            #1;
        end
        @(negedge clk);
        req_valid = 1'b0;
        wait_cycle_seen();
        chk(cycle_seen, 1'b1, "cycle start");
    endtask : start_cycle

    task automatic t_cycles;
        logic [31:0] a;
        for (int i = 0; i < 4; i++) begin
            a = 32'h8015_a5f8 ^ (i << 12);
            mask_a20 = i[1];
            start_cycle(a, 8'h81 << i, i[0]);
            if (i[1]) a[20] = 1'b0;
            chk(seen_addr, a[31:3], "cycle address");
            chk(seen_be_n, 8'(~(8'h81 << i)), "byte selects");
            chk(seen_write, i[0], "direction");
            for (int n = 0; n < 10 && cyc_finished !== 1'b1; n++) @(negedge clk);
            chk(cyc_finished, 1'b1, "cycle finished");
        end
        mask_a20 = 1'b0;
        $display("test t_cycles done");
    endtask : t_cycles

    task automatic t_inquiries;
        logic [31:0] a;
        int errs;
        for (int i = 0; i < 4; i++) begin
            a = 32'h0013_4560 + (i << 5);
            mask_a20 = 1'b1;
            if (i[1]) backoff = 1'b1;
            else float_addr = 1'b1;
            repeat (2) @(negedge clk);
            inq_addr = a[31:3];
            inq_bad_par = i[0];
            inq_req = 1'b1;
            @(negedge clk);
            inq_req = 1'b0;
            for (int n = 0; n < 10 && inq_valid !== 1'b1; n++) @(negedge clk);
            chk(inq_line, a[31:5], "inquiry line");
            errs = 0;
            repeat (6) begin
                @(negedge clk);
                if (par_err === 1'b1) errs++;
            end
            chk(errs, i[0], "parity error count");
            float_addr = 1'b0;
            backoff = 1'b0;
            mask_a20 = 1'b0;
            repeat (3) @(negedge clk);
        end
        $display("test t_inquiries done");
    endtask : t_inquiries

    task automatic t_byte_float;
        float_be = 1'b1;
        ext_be = 8'h3c;
        for (int sg = 0; sg < 2; sg++) begin
            sg_enable = sg[0];
            repeat (2) @(negedge clk);
            chk(bus_if.cpu_be_oe, !sg[0], "byte select enable");
            start_cycle(32'h0000_4000, 8'h81, 1'b0);
            chk(seen_be_n, sg[0] ? 8'hc3 : 8'h7e, "selects under float");
            repeat (4) @(negedge clk);
        end
        float_be = 1'b0;
        sg_enable = 1'b0;
        repeat (2) @(negedge clk);
        $display("test t_byte_float done");
    endtask : t_byte_float

    task automatic t_backoff;
        end_cycle = 1'b0;
        start_cycle(32'h0000_8000, 8'hff, 1'b1);
        backoff = 1'b1;
        for (int n = 0; n < 5 && cyc_aborted !== 1'b1; n++) @(negedge clk);
        chk(cyc_aborted, 1'b1, "cycle aborted");
        req_valid = 1'b1;
        repeat (4) begin
            @(negedge clk);
            chk({bus_if.cpu_addr_oe, bus_if.cpu_be_oe, bus_if.cpu_ap_oe}, 3'h0, "held released");
            chk(req_ready, 1'b0, "request refused in hold");
        end
        req_valid = 1'b0;
        backoff = 1'b0;
        end_cycle = 1'b1;
        repeat (2) @(negedge clk);
        chk({bus_if.cpu_addr_oe, bus_if.cpu_be_oe}, 2'h3, "bus driven again");
        $display("test t_backoff done");
    endtask : t_backoff

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            $display("CHECK FAILED t=%0t run too long", $time);
            tally_and_finish();
        end
    end

    initial begin
        rst = 1'b1;
        {req_valid, req_write, sg_enable, mask_a20, float_addr, float_be, backoff, inq_req, inq_bad_par} = '0;
        end_cycle = 1'b1;
        req_addr = '0;
        inq_addr = '0;
        req_be = '0;
        ext_be = '0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_cycles();
        t_inquiries();
        t_byte_float();
        t_backoff();
        tally_and_finish();
    end
endmodule : test_cpu_local_bus_front_end
